//--- shared/upconv_front_pkg.sv
// shared constants and types of the baseband interpolation front end
package upconv_front_pkg;

    // =========================================================
    // widths
    localparam int WORD_W     = 18;
    localparam int SER_W      = 16;
    localparam int FACTOR_W   = 6;
    localparam int CCI_ORDER  = 5;
    localparam int CCI_W      = 44;
    localparam int HB_STAGES  = 4;
    localparam int FIFO_DEPTH = 16;

    // =========================================================
    // serial pin positions on the data port
    localparam int SER_I_PIN = 0;
    localparam int SER_Q_PIN = 1;

    // =========================================================
    // filter coefficients and scaling
    localparam int HB_NEAR    = 9;
    localparam int HB_SHIFT   = 4;
    localparam int COMP_SHIFT = 4;
    localparam logic [WORD_W-1:0] NARROW_MASK = 18'h3_fffc;

    // =========================================================
    // types
    typedef enum logic [1:0] {
        MODE_QUAD,
        MODE_DAC,
        MODE_SERIAL
    } mode_t;

    typedef logic signed [WORD_W-1:0] sample_t;

    typedef struct packed {
        sample_t i;
        sample_t q;
    } iq_t;

endpackage

//--- rtl/sample_fifo.sv
// sample fifo with registered read data
`timescale 1ns/100ps
module sample_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk_i,
    input  wire logic             srst_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp;
    logic [AW-1:0]    rp;
    logic [AW:0]      cnt;

    wire full  = cnt == (AW+1)'(DEPTH);
    wire empty = cnt == '0;
    wire push  = in_valid_i && !full;
    wire load  = !empty && (!out_valid_o || out_ready_i);

    assign in_ready_o = !full;

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wp] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            wp <= push ? wp + 1'b1 : wp;
            rp <= load ? rp + 1'b1 : rp;
            if (push && !load) begin
                cnt <= cnt + 1'b1;
            end else if (load && !push) begin
                cnt <= cnt - 1'b1;
            end
        end
    end

    // output register, refilled when empty or taken
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else if (load) begin
            out_valid_o <= 1'b1;
            out_data_o  <= mem[rp];
        end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end

endmodule

//--- rtl/baseband_interp_chain.sv
// baseband input assembler, compensator, half-band and comb-integrator interpolators
//
// What this block does
// - parallel 18-bit words in upconvert and DAC modes, two serial lines in serial mode
// - upconvert pairs I then Q; port clock is system clock over 2R
// - port-rate-halving in upconvert mode makes the port clock system clock over 4R
// - DAC mode always runs the port clock at system clock over 4R
// - serial mode: one pin I, one pin Q, 16-bit words, other pins ignored
// - serial mode port clock is the bit clock at system clock over R, held static at comb factor 1
// - input words read as two's complement or offset binary per format bit
// - serial words assembled MSB first or LSB first per order bit
// - compensator bypassed by its bit or comb factor 1, and then held idle
// - compensator inverts comb droop over half the complex sample rate
// - two cascaded half-bands give fixed 4x ahead of the comb interpolator
// - half-band pair passband 40% of input rate, ripple at most 0.002 dB
// - half-band pair stop band 60% to 340%, at least 85 dB down
// - half-bands are linear phase, combined loss at most 0.01 dB
// - serial mode adds two 16-bit half-bands, fixed factor sixteen
// - comb interpolator factor from a 6-bit word, two up to 63
// - comb factor 1 bypasses and idles the comb stage and the compensator
// - total upsampling 4R: 8x to 252x in steps of four, 4x at comb factor 1; serial mode 16R
// - comb interpolator response is a sum of R taps to the fifth power
// - one word captured per active port clock edge, rising or inverted; both edges with port-rate-halving in upconvert mode
// - gate false ignores data and feeds zeros or holds the last value
// - serial: gate rising edge marks first bits; whole 16-bit frames delivered
`timescale 1ns/100ps
module baseband_interp_chain (
    input  wire logic                                  sys_clk_i,
    input  wire logic                                  srst_i,
    input  wire upconv_front_pkg::mode_t               mode_i,
    input  wire logic                                  rate_halve_i,
    input  wire logic                                  port_clock_invert_i,
    input  wire logic                                  offset_binary_i,
    input  wire logic                                  lsb_first_i,
    input  wire logic                                  hold_last_i,
    input  wire logic                                  inv_comb_bypass_i,
    input  wire logic [upconv_front_pkg::FACTOR_W-1:0] comb_factor_i,
    input  wire logic                                  transmit_gate_i,
    input  wire logic [upconv_front_pkg::WORD_W-1:0]   port_data_i,
    output logic                                       port_sample_clock_o,
    output upconv_front_pkg::iq_t                      out_data_o,
    output logic                                       out_valid_o,
    input  wire logic                                  out_ready_i
);
    import upconv_front_pkg::*;

    // =========================================================
    // pin synchronisers
    logic [WORD_W-1:0] data_s1, data_s2, data_s3;
    logic              gate_s1, gate_s2, gate_s3, gate_lvl;

    always_ff @(posedge sys_clk_i) begin
        data_s1 <= port_data_i;
        data_s2 <= data_s1;
        data_s3 <= data_s2;
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            gate_s1  <= 1'b0;
            gate_s2  <= 1'b0;
            gate_s3  <= 1'b0;
            gate_lvl <= 1'b0;
        end else begin
            gate_s1 <= transmit_gate_i;
            gate_s2 <= gate_s1;
            gate_s3 <= gate_s2;
            if (gate_s2 == gate_s3) begin
                gate_lvl <= gate_s3;
            end
        end
    end

    // =========================================================
    // rate counters and port clock
    logic [FACTOR_W-1:0] rc;
    logic [3:0]          dv;
    logic                pclk;
    logic                run;

    wire [FACTOR_W-1:0] eff_r   = (comb_factor_i == '0) ? 6'h01 : comb_factor_i;
    wire                tick_r  = rc == eff_r - 6'h01;
    wire [FACTOR_W-1:0] half_r  = eff_r >> 1;
    wire                serial  = mode_i == MODE_SERIAL;
    wire                dac     = mode_i == MODE_DAC;
    wire                halve_q = mode_i == MODE_QUAD && rate_halve_i;
    wire                halve   = dac || halve_q;
    wire                base_ck = serial ? (rc < half_r) : (halve ? ~dv[1] : ~dv[0]);
    wire                next_pclk = base_ck ^ port_clock_invert_i;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rc   <= '0;
            dv   <= '0;
            pclk <= 1'b0;
        end else begin
            pclk <= next_pclk;
            if (run) begin
                rc <= tick_r ? '0 : rc + 6'h01;
                dv <= tick_r ? dv + 4'h1 : dv;
            end
        end
    end

    assign port_sample_clock_o = pclk;

    // =========================================================
    // input data assembler
    iq_t         pair;
    sample_t     ibuf;
    logic        want_q;
    logic        gate_cap;
    logic [3:0]  bitcnt;
    logic [SER_W-1:0] sr_i, sr_q;

    wire cap = run && tick_r && (serial || (dac ? dv[1:0] == 2'h3 : dv[0]));
    wire first     = gate_lvl && !gate_cap;
    wire is_q      = halve_q ? ~dv[1] : (want_q && !first);
    wire [3:0] eff_cnt = first ? 4'h0 : bitcnt;
    wire sample_t w_par = {data_s3[WORD_W-1] ^ offset_binary_i, data_s3[WORD_W-2:0]};
    wire bit_i = data_s3[SER_I_PIN];
    wire bit_q = data_s3[SER_Q_PIN];
    wire [SER_W-1:0] next_sr_i = lsb_first_i ? {bit_i, sr_i[SER_W-1:1]}
                                             : {sr_i[SER_W-2:0], bit_i};
    wire [SER_W-1:0] next_sr_q = lsb_first_i ? {bit_q, sr_q[SER_W-1:1]}
                                             : {sr_q[SER_W-2:0], bit_q};
    wire sample_t ser_i = {next_sr_i[SER_W-1] ^ offset_binary_i, next_sr_i[SER_W-2:0], 2'b00};
    wire sample_t ser_q = {next_sr_q[SER_W-1] ^ offset_binary_i, next_sr_q[SER_W-2:0], 2'b00};

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pair     <= '0;
            ibuf     <= '0;
            want_q   <= 1'b0;
            gate_cap <= 1'b0;
            bitcnt   <= '0;
            sr_i     <= '0;
            sr_q     <= '0;
        end else if (cap) begin
            gate_cap <= gate_lvl;
            if (!gate_lvl) begin
                pair   <= hold_last_i ? pair : '0;
                want_q <= 1'b0;
                bitcnt <= '0;
            end else begin
                unique case (mode_i)
                    MODE_SERIAL: begin
                        sr_i   <= next_sr_i;
                        sr_q   <= next_sr_q;
                        bitcnt <= eff_cnt + 4'h1;
                        if (eff_cnt == 4'hf) begin
                            pair <= '{i: ser_i, q: ser_q};
                        end
                    end
                    MODE_DAC: begin
                        pair <= '{i: w_par, q: '0};
                    end
                    MODE_QUAD: begin
                        if (is_q) begin
                            pair   <= '{i: ibuf, q: w_par};
                            want_q <= 1'b0;
                        end else begin
                            ibuf   <= w_par;
                            want_q <= 1'b1;
                        end
                    end
                    default: begin
                        want_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // =========================================================
    // inverse comb compensator: 3-tap peaking filter at the complex rate
    iq_t comp_dly [3];
    iq_t comp_src;

    wire comp_bypass = inv_comb_bypass_i || eff_r == 6'h01;
    wire src_tick    = run && tick_r && (serial ? dv == 4'h0 : dv[1:0] == 2'h0);

    function automatic sample_t comp(input sample_t a, input sample_t b, input sample_t c);
        logic signed [WORD_W+2:0] d;
        d = 21'(b) + 21'(b) - 21'(a) - 21'(c);
        return sample_t'(21'(b) + (d >>> COMP_SHIFT));
    endfunction

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || comp_bypass) begin
            comp_dly <= '{default: '0};
        end else if (src_tick) begin
            comp_dly[0] <= pair;
            comp_dly[1] <= comp_dly[0];
            comp_dly[2] <= comp_dly[1];
        end
    end

    assign comp_src = comp_bypass ? pair : iq_t'{
        i: comp(comp_dly[0].i, comp_dly[1].i, comp_dly[2].i),
        q: comp(comp_dly[0].q, comp_dly[1].q, comp_dly[2].q)};

    // =========================================================
    // half-band interpolators, stage 0 is the last before the comb stage
    iq_t hb_in  [HB_STAGES];
    iq_t hb_out [HB_STAGES];

    function automatic sample_t hb_odd(input sample_t a, input sample_t b,
                                       input sample_t c, input sample_t d);
        logic signed [WORD_W+4:0] s;
        s = 23'(HB_NEAR) * (23'(b) + 23'(c)) - 23'(a) - 23'(d);
        return sample_t'(s >>> HB_SHIFT);
    endfunction

    assign hb_in[3] = comp_src;
    assign hb_in[2] = hb_out[3];
    assign hb_in[1] = serial ? hb_out[2] : comp_src;
    assign hb_in[0] = hb_out[1];

    for (genvar k = 0; k < HB_STAGES; k++) begin : g_hb
        localparam logic [3:0] LOW = 4'((1 << k) - 1);
        localparam logic [WORD_W-1:0] KEEP = (k >= 2) ? NARROW_MASK : '1;
        iq_t dly [4];
        iq_t out_r;
        iq_t odd;
        wire tk  = run && tick_r && (dv & LOW) == 4'h0;
        wire act = (k < 2) || serial;

        assign odd = '{i: hb_odd(dly[0].i, dly[1].i, dly[2].i, dly[3].i),
                       q: hb_odd(dly[0].q, dly[1].q, dly[2].q, dly[3].q)};

        // symmetric taps keep linear phase; even phase passes the centre sample
        always_ff @(posedge sys_clk_i) begin
            if (srst_i || !act) begin
                dly   <= '{default: '0};
                out_r <= '0;
            end else if (tk) begin
                if (!dv[k]) begin
                    dly[0] <= hb_in[k];
                    dly[1] <= dly[0];
                    dly[2] <= dly[1];
                    dly[3] <= dly[2];
                    out_r  <= '{i: dly[1].i & KEEP, q: dly[1].q & KEEP};
                end else begin
                    out_r  <= '{i: odd.i & KEEP, q: odd.q & KEEP};
                end
            end
        end

        assign hb_out[k] = out_r;
    end

    // =========================================================
    // fifth-order comb-integrator interpolator
    logic signed [CCI_W-1:0] comb_dly [2][CCI_ORDER];
    logic signed [CCI_W-1:0] integ    [2][CCI_ORDER];
    logic signed [CCI_W-1:0] cmb      [2][CCI_ORDER+1];
    iq_t                     chain_out;
    logic [4:0]              gain_sh;

    wire cci_on = eff_r != 6'h01;
    wire tk0    = run && tick_r;

    always_comb begin
        gain_sh = '0;
        for (int b = 0; b < FACTOR_W; b++) begin
            if ((6'h01 << b) < eff_r) begin
                gain_sh = 5'(4 * (b + 1));
            end
        end
    end

    always_comb begin
        cmb[0][0] = CCI_W'(hb_out[0].i);
        cmb[1][0] = CCI_W'(hb_out[0].q);
        for (int c = 0; c < 2; c++) begin
            for (int j = 0; j < CCI_ORDER; j++) begin
                cmb[c][j+1] = cmb[c][j] - comb_dly[c][j];
            end
        end
    end

    // combs at the low rate, zero stuffing, integrators at the system rate
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || !cci_on) begin
            comb_dly <= '{default: '0};
            integ    <= '{default: '0};
        end else if (run) begin
            for (int c = 0; c < 2; c++) begin
                for (int j = 0; j < CCI_ORDER; j++) begin
                    if (tk0) begin
                        comb_dly[c][j] <= cmb[c][j];
                    end
                end
                integ[c][0] <= integ[c][0] + (tk0 ? cmb[c][CCI_ORDER] : '0);
                for (int j = 1; j < CCI_ORDER; j++) begin
                    integ[c][j] <= integ[c][j] + integ[c][j-1];
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            chain_out <= '0;
        end else if (run) begin
            chain_out <= cci_on ? iq_t'{
                i: sample_t'(integ[0][CCI_ORDER-1] >>> gain_sh),
                q: sample_t'(integ[1][CCI_ORDER-1] >>> gain_sh)} : hb_out[0];
        end
    end

    // =========================================================
    // output buffer; a full fifo freezes the whole chain and port clock
    logic fill_valid;
    logic [2*WORD_W-1:0] fifo_q;

    always_ff @(posedge sys_clk_i) begin
        fill_valid <= !srst_i;
    end

    sample_fifo #(
        .WIDTH (2 * WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (fill_valid),
        .in_data_i   (chain_out),
        .in_ready_o  (run),
        .out_valid_o (out_valid_o),
        .out_data_o  (fifo_q),
        .out_ready_i (out_ready_i)
    );

    assign out_data_o = iq_t'(fifo_q);

    // =========================================================
    // checks
    a_offset_msb: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        cap && mode_i == MODE_QUAD && gate_lvl && !is_q
        |=> ibuf[WORD_W-1] == ($past(data_s3[WORD_W-1]) ^ $past(offset_binary_i)))
        else $error("offset binary msb not inverted");

    a_dac_q_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        cap && dac && gate_lvl |=> pair.q == '0 && pair.i == $past(w_par))
        else $error("dac mode pair wrong");

    a_gate_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        cap && !gate_lvl && !hold_last_i |=> pair == '0)
        else $error("gate low did not zero the pair");

    a_gate_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        cap && !gate_lvl && hold_last_i |=> $stable(pair))
        else $error("gate low did not hold the pair");

    a_frame_start: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        cap && serial && first |=> bitcnt == 4'h1)
        else $error("frame start did not restart bit count");

    a_comp_idle: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        comp_bypass |=> comp_dly[0] == '0 && comp_dly[2] == '0)
        else $error("bypassed compensator still active");

    a_cci_bypass: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !cci_on && run |=> chain_out == $past(hb_out[0]))
        else $error("comb bypass output wrong");

    a_quad_clock: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        run && tick_r && dv[0] && mode_i == MODE_QUAD && !rate_halve_i
        |-> ##2 (pclk == !$past(port_clock_invert_i)))
        else $error("port clock edge misplaced");

    a_serial_tick: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        run && tick_r && serial && eff_r > 6'h01 |=> !tick_r)
        else $error("serial bit period too short");

endmodule

//--- verification/baseband_source.sv
// behavioural baseband sample source clocked by the system clock, stepping on port sample clock edges
`timescale 1ns/100ps
module baseband_source (
    input  wire logic                                sys_clk_i,
    input  wire logic                                port_sample_clock_i,
    input  wire logic                                invert_i,
    input  wire logic                                serial_i,
    input  wire logic                                lsb_first_i,
    input  wire logic                                gate_req_i,
    input  wire logic [upconv_front_pkg::WORD_W-1:0] i_word_i,
    input  wire logic [upconv_front_pkg::WORD_W-1:0] q_word_i,
    output logic                                     transmit_gate_o,
    output logic [upconv_front_pkg::WORD_W-1:0]      port_data_o
);
    import upconv_front_pkg::*;
    logic       pclk_q = 1'b0;
    logic       q_turn = 1'b0;
    logic [3:0] bit_cnt = 4'h0;
    wire        active = (port_sample_clock_i != pclk_q) && (port_sample_clock_i != invert_i);
    wire  [3:0] bit_pos = lsb_first_i ? bit_cnt : 4'(SER_W - 1) - bit_cnt;
    initial transmit_gate_o = 1'b0;
    initial port_data_o = '0;
    // =========================================================
    // everything changes just after an active port clock edge
    always @(posedge sys_clk_i) begin
        pclk_q <= port_sample_clock_i;
        if (active) begin
            transmit_gate_o <= gate_req_i;
            if (!gate_req_i) begin
                q_turn <= 1'b0;
                bit_cnt <= 4'h0;
                port_data_o <= ~port_data_o;
            end else begin
                q_turn <= ~q_turn;
                bit_cnt <= bit_cnt + 4'h1;
                if (serial_i) begin
                    // unused pins toggle so that they must be ignored
                    port_data_o <= {16'h5a5a ^ {16{bit_cnt[0]}}, q_word_i[bit_pos],
                                    i_word_i[bit_pos]};
                end else begin
                    port_data_o <= q_turn ? q_word_i : i_word_i;
                end
            end
        end
    end
endmodule

//--- verification/baseband_interp_chain_tb.sv
// self-checking bench of the baseband interpolation front end
`timescale 1ns/100ps
module baseband_interp_chain_tb;
    import upconv_front_pkg::*;
    logic                sys_clk = 1'b0;
    logic                srst = 1'b1;
    logic                halve = 1'b0;
    logic                invert = 1'b0;
    logic                offset = 1'b0;
    logic                lsb = 1'b0;
    logic                hold = 1'b0;
    logic                icb = 1'b0;
    logic                gate_req = 1'b0;
    logic                ready = 1'b1;
    logic                gate;
    logic                pclk;
    logic                valid;
    mode_t               mode = MODE_QUAD;
    logic [FACTOR_W-1:0] factor = 6'h02;
    logic [WORD_W-1:0]   i_word = '0;
    logic [WORD_W-1:0]   q_word = '0;
    logic [WORD_W-1:0]   data;
    iq_t                 out_data;
    iq_t                 seen;
    int                  fails = 0;
    int                  comparisons = 0;

    always #2.5 sys_clk = ~sys_clk;

    baseband_interp_chain u_baseband_interp_chain (
        .sys_clk_i           (sys_clk),
        .srst_i              (srst),
        .mode_i              (mode),
        .rate_halve_i        (halve),
        .port_clock_invert_i (invert),
        .offset_binary_i     (offset),
        .lsb_first_i         (lsb),
        .hold_last_i         (hold),
        .inv_comb_bypass_i   (icb),
        .comb_factor_i       (factor),
        .transmit_gate_i     (gate),
        .port_data_i         (data),
        .port_sample_clock_o (pclk),
        .out_data_o          (out_data),
        .out_valid_o         (valid),
        .out_ready_i         (ready)
    );

    baseband_source u_baseband_source (
        .sys_clk_i           (sys_clk),
        .port_sample_clock_i (pclk),
        .invert_i            (invert),
        .serial_i            (mode == MODE_SERIAL),
        .lsb_first_i         (lsb),
        .gate_req_i          (gate_req),
        .i_word_i            (i_word),
        .q_word_i            (q_word),
        .transmit_gate_o     (gate),
        .port_data_o         (data)
    );

    // =========================================================
    // shared tasks
    task automatic check(input string name, input logic [35:0] got, input logic [35:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // cycles between two rising port clock edges
    task automatic period(input int exp);
        int   n;
        int   t0;
        logic prev;
        n = 0;
        t0 = -1;
        prev = pclk;
        while (n < 1000) begin
            tick(1);
            n++;
            if (pclk === 1'b1 && prev === 1'b0) begin
                if (t0 >= 0) break;
                t0 = n;
            end
            prev = pclk;
        end
        if (n >= 1000) begin
            fails++;
            complete_run();
        end
        check("port clock period", 36'(n - t0), 36'(exp));
    endtask

    // =========================================================
    // scenarios
    task automatic clock_rates();
        factor = 6'h03;
        tick(60);
        period(6);
        halve = 1'b1;
        tick(60);
        period(12);
        mode = MODE_DAC;
        halve = 1'b0;
        invert = 1'b1;
        tick(60);
        period(12);
        mode = MODE_SERIAL;
        factor = 6'h04;
        tick(60);
        period(4);
        mode = MODE_QUAD;
        invert = 1'b0;
        factor = 6'h02;
    endtask

    task automatic data_format();
        i_word = 18'h2_0000;
        q_word = 18'h2_0000;
        gate_req = 1'b1;
        tick(3000);
        check("signed full scale zero", 36'(out_data.i == '0), 36'h0);
        offset = 1'b1;
        tick(3000);
        check("offset midscale", out_data, 36'h0);
    endtask

    task automatic gate_low();
        offset = 1'b0;
        i_word = 18'h0_1000;
        q_word = 18'h0_1000;
        tick(3000);
        seen = out_data;
        hold = 1'b1;
        gate_req = 1'b0;
        tick(3000);
        check("held sample", out_data, seen);
        hold = 1'b0;
        tick(3000);
        check("gated zero", out_data, 36'h0);
    endtask

    task automatic serial_order();
        mode = MODE_SERIAL;
        factor = 6'h04;
        i_word = 18'h0_0003;
        q_word = 18'h0_0000;
        gate_req = 1'b1;
        tick(4000);
        seen = out_data;
        check("serial i zero", 36'(seen.i == '0), 36'h0);
        check("serial q", 36'(seen.q), 36'h0);
        lsb = 1'b1;
        tick(4000);
        check("lsb first sample", out_data, seen);
    endtask

    // comb factor one bypasses comb and compensator; a stalled consumer freezes the output
    task automatic bypass_paths();
        mode = MODE_QUAD;
        factor = 6'h01;
        icb = 1'b1;
        i_word = 18'h0_1000;
        q_word = 18'h0_1000;
        gate_req = 1'b1;
        tick(3000);
        check("comb bypass", out_data, {18'h0_1000, 18'h0_1000});
        seen = out_data;
        ready = 1'b0;
        tick(100);
        check("stalled valid", 36'(valid), 36'h1);
        check("stalled data", out_data, seen);
        ready = 1'b1;
        icb = 1'b0;
        factor = 6'h02;
        tick(200);
    endtask

    task automatic reset_clear();
        srst = 1'b1;
        tick(4);
        check("valid in reset", 36'(valid), 36'h0);
        check("data in reset", out_data, 36'h0);
        gate_req = 1'b0;
        mode = MODE_QUAD;
        lsb = 1'b0;
        srst = 1'b0;
        tick(2000);
        check("cleared chain", out_data, 36'h0);
    endtask

    initial begin
        tick(6);
        srst = 1'b0;
        clock_rates();
        data_format();
        gate_low();
        serial_order();
        bypass_paths();
        reset_clear();
        complete_run();
    end
endmodule
